// ---- hdl/tmr_pkg.sv ----
/*
  constants shared by the single-channel up timer: register map, fields,
  reset values and modes.
  assumes a 32-bit axi4-lite slave with word-aligned registers.
*/
package tmr_pkg;
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_INTEN  = 8'h0C;
  localparam logic [7:0] OFS_FLAGS  = 8'h10;
  localparam logic [7:0] OFS_EVGEN  = 8'h14;
  localparam logic [7:0] OFS_CHCTL  = 8'h18;
  localparam logic [7:0] OFS_CHOUT  = 8'h20;
  localparam logic [7:0] OFS_COUNT  = 8'h24;
  localparam logic [7:0] OFS_PRESC  = 8'h28;
  localparam logic [7:0] OFS_RELOAD = 8'h2C;
  localparam logic [7:0] OFS_CHVAL  = 8'h34;
  localparam int BIT_RUN    = 0;
  localparam int BIT_UPDATE_DISABLE_BIT  = 1;
  localparam int BIT_UPFLAG = 0;
  localparam int BIT_CHFLAG = 1;
  localparam int BIT_OVCAP  = 9;
  localparam int BIT_UPGEN  = 0;
  localparam int BIT_CHGEN  = 1;
  localparam int BIT_CHEN   = 0;
  localparam int BIT_CHPOL  = 1;
  localparam int BIT_CHNPOL = 3;
  localparam int BIT_SHADOW = 3;
  localparam int POS_MODE   = 0;
  localparam int POS_CMPCTL = 4;
  localparam int POS_EVPSC  = 2;
  localparam int POS_FILT   = 4;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  localparam logic [2:0] CMP_FROZEN = 3'h0;
  localparam logic [2:0] CMP_SET    = 3'h1;
  localparam logic [2:0] CMP_CLEAR  = 3'h2;
  localparam logic [2:0] CMP_TOGGLE = 3'h3;
  localparam logic [2:0] CMP_LOW    = 3'h4;
  localparam logic [2:0] CMP_HIGH   = 3'h5;
  localparam logic [2:0] CMP_PWM0   = 3'h6;
  localparam logic [2:0] CMP_PWM1   = 3'h7;
endpackage

// ---- hdl/tmr_presc.sv ----
/*
  prescaler: turns the timer clock into one-cycle counting enables.
  assumes run and clear come from logic on the same clock.
*/
`timescale 1ns/1ns
module tmr_presc import tmr_pkg::*; #(
  parameter int W = 16
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         run,
  input  wire logic         clr,
  input  wire logic [W-1:0] div,
  output logic              tick
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } st_s;
  st_s q;
  st_s d;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (clr) begin
      d.cnt = '0; // RQ23
    end else if (run) begin // RQ5
      if (q.cnt >= div) begin // RQ3
        d.cnt = '0;
        d.tick = 1'b1;
      end else begin
        d.cnt = q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;

  AST_NO_TICK_STOPPED: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(run) && !$past(clr) |-> !tick) else $error("tick while stopped"); // RQ5
endmodule

// ---- hdl/tmr_capin.sv ----
/*
  capture input stage: synchroniser, filter, edge select, event prescaler.
  assumes chan_in is asynchronous to aclk.
*/
`timescale 1ns/1ns
module tmr_capin import tmr_pkg::*; (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       chan_in,
  input  wire logic [3:0] filt,
  input  wire logic       pol,
  input  wire logic       npol,
  input  wire logic [1:0] evpsc,
  input  wire logic       en,
  output logic            cap
);
  typedef struct packed {
    logic [1:0]  sync;
    logic        filt_lvl;
    logic [15:0] fcnt;
    logic        prev;
    logic [2:0]  ecnt;
    logic        cap;
  } st_s;
  st_s q;
  st_s d;
  logic raw;
  logic edge_ok;
  logic [3:0] need;

  always_comb begin
    d = q;
    d.sync = {q.sync[0], chan_in}; // RQ9
    raw = q.sync[1];
    if (raw == q.filt_lvl) begin
      d.fcnt = '0;
    end else if (q.fcnt >= {12'h000, filt}) begin // RQ9
      d.filt_lvl = raw;
      d.fcnt = '0;
    end else begin
      d.fcnt = q.fcnt + 16'h0001;
    end
    d.prev = q.filt_lvl;
    // both-edges when both polarity bits set; rising unless pol alone
    if (pol && npol) begin
      edge_ok = q.filt_lvl != q.prev;
    end else if (pol) begin
      edge_ok = !q.filt_lvl && q.prev;
    end else begin
      edge_ok = q.filt_lvl && !q.prev;
    end
    need = 4'h1 << evpsc;
    d.cap = 1'b0;
    if (!en) begin
      d.ecnt = '0;
    end else if (edge_ok) begin
      if ({1'b0, q.ecnt} + 4'h1 >= need) begin // RQ9
        d.ecnt = '0;
        d.cap = 1'b1;
      end else begin
        d.ecnt = q.ecnt + 3'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign cap = q.cap;

  AST_CAP_NEEDS_EN: assert property (@(posedge aclk) disable iff (!aresetn)
    cap |-> $past(en)) else $error("capture without enable"); // RQ9
endmodule

// ---- hdl/tmr_top.sv ----
/*
  single-channel 16-bit up timer with axi4-lite register slave.
  assumes one 50 MHz clock; channel input is an asynchronous pin.
*/
// Functional notes
// RQ1 - 16-bit counter counts up, wraps at reload
// RQ2 - overflow past reload makes update event
// RQ3 - counting clock divided by one to 65536
// RQ4 - new prescale used from next update
// RQ5 - prescaler runs only while run bit set
// RQ6 - update-generate bit zeroes counter, makes update
// RQ7 - update-disable blocks updates and shadow loads
// RQ8 - update loads reload and prescale working copies
// RQ9 - input synchronised, filtered, edge-selected, prescaled
// RQ10 - capture stores counter, sets flag, interrupt
// RQ11 - channel value read-only in input mode
// RQ12 - capture with flag set sets overcapture
// RQ13 - event-generate bit forces channel event
// RQ14 - compare match sets flag, interrupt if enabled
// RQ15 - frozen, set, clear, toggle on match
// RQ16 - modes four, five force inactive, active
// RQ17 - pwm modes: period reload, duty value
// RQ18 - pwm0 value above reload stays active
// RQ19 - pwm0 value zero stays inactive
// RQ20 - debug halt with hold bit freezes counter
// RQ21 - pwm0 active below value; pwm1 inverse
// RQ22 - shadowed channel value loads on update
// RQ23 - soft update clears prescaler, self-clears bit
// RQ24 - hardware sets flags, software clears them
// RQ25 - polarity inverts enabled output pin
// RQ26 - reset: stopped, zero, flags clear, frozen
`timescale 1ns/1ns
module tmr_top import tmr_pkg::*; (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        channel_input,
  input  wire logic        core_halted,
  input  wire logic        debug_hold_bit,
  output logic             chan_out,
  output logic             chan_out_en,
  output logic             update_irq,
  output logic             channel_irq
);
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        arready;
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        counter_run_bit;
    logic        update_disable_bit;
    logic        update_irq_en;
    logic        channel_interrupt_enable;
    logic        update_flag;
    logic        channel_flag;
    logic        channel_over_capture_flag;
    logic        update_generate_bit;
    logic        channel_event_generate_bit;
    logic [1:0]  channel_mode_select;
    logic        compare_shadow_enable;
    logic [2:0]  compare_control_field;
    logic [3:0]  capture_filter_setting;
    logic [1:0]  cap_evpsc;
    logic        channel_output_enable;
    logic        channel_polarity_bit;
    logic        complementary_polarity_bit;
    logic [15:0] count;
    logic [15:0] prescale_setting;
    logic [15:0] prescale_value;
    logic [15:0] reload_value_register;
    logic [15:0] reload_work;
    logic [15:0] channel_value;
    logic [15:0] cmp_work;
    logic        output_reference;
    logic        pin;
    logic        pin_en;
    logic        uirq;
    logic        cirq;
  } st_s;
  st_s q;
  st_s d;

  logic tick;
  logic cap_raw;
  logic presc_clr;
  logic is_input;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic known(input logic [7:0] a);
    return a == OFS_CTRL || a == OFS_INTEN || a == OFS_FLAGS || a == OFS_EVGEN ||
           a == OFS_CHCTL || a == OFS_CHOUT || a == OFS_COUNT || a == OFS_PRESC ||
           a == OFS_RELOAD || a == OFS_CHVAL;
  endfunction

  assign presc_clr = q.update_generate_bit;
  assign is_input  = q.channel_mode_select != 2'b00;

  tmr_presc #(.W(16)) u_presc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (q.counter_run_bit && !(core_halted && debug_hold_bit)), // RQ20
    .clr     (presc_clr),
    .div     (q.prescale_value),
    .tick    (tick)
  );

  tmr_capin u_capin (
    .aclk    (aclk),
    .aresetn (aresetn),
    .chan_in (channel_input),
    .filt    (q.capture_filter_setting),
    .pol     (q.channel_polarity_bit),
    .npol    (q.complementary_polarity_bit),
    .evpsc   (q.cap_evpsc),
    .en      (q.channel_output_enable && is_input),
    .cap     (cap_raw)
  );

  always_comb begin
    logic [31:0] wv;
    logic        wr;
    logic        upd;
    logic        ch_ev;
    logic        match;
    logic        pwm_act;
    logic        do_cap;
    wv = '0;
    wr = 1'b0;
    upd = 1'b0;
    ch_ev = 1'b0;
    match = 1'b0;
    pwm_act = 1'b0;
    do_cap = 1'b0;
    d = q;
    // bus handshake: address and data taken in either order
    if (s_axi_awvalid && q.awready) begin
      d.aw_got = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_got = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) d.bvalid = 1'b0;
    if (s_axi_rvalid && s_axi_rready) d.rvalid = 1'b0;
    wr = q.aw_got && q.w_got && !q.bvalid;
    d.update_generate_bit = 1'b0; // RQ23
    d.channel_event_generate_bit = 1'b0;
    // counter: advances only on a prescaler tick; the update-generate bit zeroes it without one
    if (tick) begin
      if (q.count >= q.reload_work) begin
        d.count = '0; // RQ1
        upd = !q.update_disable_bit; // RQ2 RQ7
      end else begin
        d.count = q.count + 16'h0001; // RQ1
      end
    end
    if (q.update_generate_bit) begin
      d.count = '0; // RQ6
      upd = !q.update_disable_bit; // RQ7
    end
    if (upd) begin
      d.update_flag = 1'b1; // RQ24
      d.prescale_value = q.prescale_setting; // RQ4 RQ8
      d.reload_work = q.reload_value_register; // RQ8
      if (q.compare_shadow_enable) d.cmp_work = q.channel_value; // RQ22
    end
    if (!q.compare_shadow_enable) d.cmp_work = q.channel_value; // RQ22
    // channel events
    match = !is_input && tick && (q.count == q.cmp_work); // RQ14
    do_cap = is_input && (cap_raw || q.channel_event_generate_bit);
    ch_ev = match || cap_raw && is_input || q.channel_event_generate_bit; // RQ13
    if (do_cap) begin
      d.channel_value = q.count; // RQ10
      if (q.channel_flag) d.channel_over_capture_flag = 1'b1; // RQ12
    end
    // output reference
    pwm_act = q.count < q.cmp_work; // RQ18 RQ19 RQ21
    case (q.compare_control_field)
      CMP_FROZEN: d.output_reference = q.output_reference; // RQ15
      CMP_SET:    if (match) d.output_reference = 1'b1; // RQ15
      CMP_CLEAR:  if (match) d.output_reference = 1'b0; // RQ15
      CMP_TOGGLE: if (match) d.output_reference = !q.output_reference; // RQ15
      CMP_LOW:    d.output_reference = 1'b0; // RQ16
      CMP_HIGH:   d.output_reference = 1'b1; // RQ16
      CMP_PWM0:   d.output_reference = pwm_act; // RQ17 RQ21
      CMP_PWM1:   d.output_reference = !pwm_act; // RQ17 RQ21
      default:    d.output_reference = q.output_reference;
    endcase
    d.pin_en = q.channel_output_enable && !is_input;
    d.pin = q.output_reference ^ q.channel_polarity_bit; // RQ25
    // register writes; hardware set wins over software clear
    if (wr) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = known(q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      case (q.aw_addr)
        OFS_CTRL: begin
          wv = merge({30'h0, q.update_disable_bit, q.counter_run_bit}, q.w_data, q.w_strb);
          d.counter_run_bit = wv[BIT_RUN];
          d.update_disable_bit = wv[BIT_UPDATE_DISABLE_BIT];
        end
        OFS_INTEN: begin
          wv = merge({30'h0, q.channel_interrupt_enable, q.update_irq_en}, q.w_data, q.w_strb);
          d.update_irq_en = wv[BIT_UPFLAG];
          d.channel_interrupt_enable = wv[BIT_CHFLAG];
        end
        OFS_FLAGS: begin
          wv = merge(32'hFFFFFFFF, q.w_data, q.w_strb);
          d.update_flag = d.update_flag & (wv[BIT_UPFLAG] | upd); // RQ24
          d.channel_flag = q.channel_flag & (wv[BIT_CHFLAG] | ch_ev); // RQ24
          d.channel_over_capture_flag = d.channel_over_capture_flag
                                        & (wv[BIT_OVCAP] | (do_cap & q.channel_flag));
        end
        OFS_EVGEN: begin
          wv = merge(32'h0, q.w_data, q.w_strb);
          d.update_generate_bit = wv[BIT_UPGEN]; // RQ6
          d.channel_event_generate_bit = wv[BIT_CHGEN]; // RQ13
        end
        OFS_CHCTL: begin
          wv = merge({25'h0, q.compare_control_field, q.compare_shadow_enable, 1'b0,
                      q.channel_mode_select} | {24'h0, q.capture_filter_setting,
                      q.cap_evpsc, 2'b00}, q.w_data, q.w_strb);
          d.channel_mode_select = wv[POS_MODE +: 2];
          d.cap_evpsc = wv[POS_EVPSC +: 2];
          d.capture_filter_setting = wv[POS_FILT +: 4];
          d.compare_shadow_enable = wv[BIT_SHADOW];
          d.compare_control_field = wv[POS_CMPCTL +: 3];
        end
        OFS_CHOUT: begin
          wv = merge({28'h0, q.complementary_polarity_bit, 1'b0, q.channel_polarity_bit,
                      q.channel_output_enable}, q.w_data, q.w_strb);
          d.channel_output_enable = wv[BIT_CHEN];
          d.channel_polarity_bit = wv[BIT_CHPOL];
          d.complementary_polarity_bit = wv[BIT_CHNPOL];
        end
        OFS_COUNT:  d.count = 16'(merge({16'h0, q.count}, q.w_data, q.w_strb));
        OFS_PRESC:  d.prescale_setting = 16'(merge({16'h0, q.prescale_setting},
                                                   q.w_data, q.w_strb)); // RQ4
        OFS_RELOAD: d.reload_value_register = 16'(merge({16'h0, q.reload_value_register},
                                                        q.w_data, q.w_strb));
        OFS_CHVAL: begin
          if (!is_input) begin // RQ11
            d.channel_value = 16'(merge({16'h0, q.channel_value}, q.w_data, q.w_strb));
          end
        end
        default: d.bresp = RESP_SLVERR;
      endcase
    end
    if (ch_ev) d.channel_flag = 1'b1; // RQ10 RQ14 RQ24
    // reads
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFS_CTRL:   d.rdata = {30'h0, q.update_disable_bit, q.counter_run_bit};
        OFS_INTEN:  d.rdata = {30'h0, q.channel_interrupt_enable, q.update_irq_en};
        OFS_FLAGS:  d.rdata = {22'h0, q.channel_over_capture_flag, 7'h0, q.channel_flag,
                               q.update_flag};
        OFS_CHCTL:  d.rdata = {25'h0, q.compare_control_field, q.compare_shadow_enable,
                               1'b0, q.channel_mode_select} | {24'h0, q.capture_filter_setting,
                               q.cap_evpsc, 2'b00};
        OFS_CHOUT:  d.rdata = {28'h0, q.complementary_polarity_bit, 1'b0,
                               q.channel_polarity_bit, q.channel_output_enable};
        OFS_COUNT:  d.rdata = {16'h0, q.count};
        OFS_PRESC:  d.rdata = {16'h0, q.prescale_setting};
        OFS_RELOAD: d.rdata = {16'h0, q.reload_value_register};
        OFS_CHVAL:  d.rdata = {16'h0, q.channel_value};
        default:    d.rdata = '0;
      endcase
    end
    d.uirq = d.update_flag && q.update_irq_en;
    d.cirq = d.channel_flag && q.channel_interrupt_enable; // RQ10 RQ14
    d.awready = !d.aw_got;
    d.wready = !d.w_got;
    d.arready = !d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0; // RQ26
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign chan_out      = q.pin;
  assign chan_out_en   = q.pin_en;
  assign update_irq    = q.uirq;
  assign channel_irq   = q.cirq;

  AST_WRAP_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && q.count >= q.reload_work && !q.update_generate_bit |=> q.count == 16'h0000)
    else $error("counter did not wrap"); // RQ1
  AST_UPD_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && q.count >= q.reload_work && !q.update_disable_bit |=> q.update_flag)
    else $error("overflow without update flag"); // RQ2
  AST_UPG_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    q.update_generate_bit |=> q.count == 16'h0000 && !q.update_generate_bit)
    else $error("soft update did not clear"); // RQ6
  AST_UPDATE_DISABLE_BIT_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    q.update_disable_bit |=> $stable(q.reload_work) && $stable(q.prescale_value))
    else $error("shadow loaded while updates disabled"); // RQ7
  AST_CAP_COPY: assert property (@(posedge aclk) disable iff (!aresetn)
    cap_raw && is_input |=> q.channel_value == $past(q.count) && q.channel_flag)
    else $error("capture did not store counter"); // RQ10
  AST_RO_INPUT: assert property (@(posedge aclk) disable iff (!aresetn)
    is_input && !cap_raw && !q.channel_event_generate_bit |=> $stable(q.channel_value))
    else $error("channel value changed in input mode"); // RQ11
  AST_OVCAP: assert property (@(posedge aclk) disable iff (!aresetn)
    cap_raw && is_input && q.channel_flag |=> q.channel_over_capture_flag)
    else $error("overcapture flag missed"); // RQ12
  AST_FORCE: assert property (@(posedge aclk) disable iff (!aresetn)
    q.compare_control_field == CMP_HIGH |=> q.output_reference)
    else $error("forced high not applied"); // RQ16
  AST_HALT: assert property (@(posedge aclk) disable iff (!aresetn)
    core_halted && debug_hold_bit && $past(core_halted && debug_hold_bit)
    && !q.update_generate_bit && !(q.aw_got && q.w_got) |=> $stable(q.count))
    else $error("counter moved during debug halt"); // RQ20
endmodule

// ---- verification/test_single_channel_up_timer.sv ----
/*
  self-checking bench for the single-channel up timer: registers, counting,
  prescaler, debug hold, compare modes, pwm and capture.
  assumes tmr_top with its axi4-lite slave on a 50 MHz aclk.
*/
`timescale 1ns/1ns
module test_single_channel_up_timer import tmr_pkg::*; ;
  logic        aclk = 0;
  logic        aresetn = 0;
  logic [7:0]  awaddr = 0;
  logic [7:0]  araddr = 0;
  logic [31:0] wdata = 0;
  logic        awvalid = 0;
  logic        wvalid = 0;
  logic        bready = 0;
  logic        arvalid = 0;
  logic        rready = 0;
  logic        chin = 0;
  logic        halted = 0;
  logic        hold = 0;
  wire         awready, wready, bvalid, arready, rvalid, chout, choe, uirq, cirq;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  logic [1:0]  rs, bs;
  logic [31:0] v, dv, n;
  int          n_mismatch = 0;
  int          cmp_count = 0;

  always #10 aclk = ~aclk;

  tmr_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .channel_input(chin), .core_halted(halted),
    .debug_hold_bit(hold), .chan_out(chout), .chan_out_en(choe),
    .update_irq(uirq), .channel_irq(cirq));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic rng(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
    cmp_count++;
    if (^g === 1'bx || g < lo || g > hi) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h..%h", $time, g, lo, hi);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    awaddr <= a;
    wdata <= x;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
    end while (!bvalid);
    bs = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready && arvalid) arvalid <= 1'b0;
    end while (!rvalid);
    x = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // both reads have the same shape, so the counter is sampled 200 cycles apart
  task automatic meas;
    logic [31:0] a, b;
    rd(OFS_COUNT, a);
    repeat (197) @(posedge aclk);
    rd(OFS_COUNT, b);
    dv = b - a;
  endtask

  task automatic ones;
    n = 0;
    repeat (3) @(posedge aclk);
    repeat (10) begin
      @(posedge aclk);
      n = n + 32'(chout);
    end
  endtask

  task automatic setm(input logic [2:0] m);
    wr(OFS_CHCTL, 32'(m) << POS_CMPCTL);
    repeat (3) @(posedge aclk);
  endtask

  task automatic t_reset;
    rd(OFS_CTRL, v);
    chk(v, 32'h0);
    rd(OFS_FLAGS, v);
    chk(v, 32'h0);
    rd(OFS_CHCTL, v);
    chk(v, 32'h0);
    rd(OFS_COUNT, v);
    chk(v, 32'h0);
    chk(32'({chout, uirq, cirq}), 32'h0);
    rd(8'hF0, v);
    chk(32'(rs), 32'(RESP_SLVERR));
    chk(v, 32'h0);
    wr(8'hF0, 32'h0);
    chk(32'(bs), 32'(RESP_SLVERR));
  endtask

  task automatic t_count;
    wr(OFS_INTEN, 32'h1);
    chk(32'(bs), 32'(RESP_OKAY));
    wr(OFS_RELOAD, 32'h3);
    wr(OFS_COUNT, 32'h5);
    wr(OFS_EVGEN, 32'h1);
    rd(OFS_EVGEN, v);
    chk(v, 32'h0);
    rd(OFS_COUNT, v);
    chk(v, 32'h0);
    rd(OFS_FLAGS, v);
    chk(32'(v[BIT_UPFLAG]), 32'h1);
    chk(32'(uirq), 32'h1);
    wr(OFS_FLAGS, 32'h0);
    rd(OFS_FLAGS, v);
    chk(v, 32'h0);
    chk(32'(uirq), 32'h0);
    meas;
    chk(dv, 32'h0);
    wr(OFS_CTRL, 32'h1);
    repeat (12) begin
      rd(OFS_COUNT, v);
      rng(v, 32'h0, 32'h3);
    end
    rd(OFS_FLAGS, v);
    chk(32'(v[BIT_UPFLAG]), 32'h1);
    wr(OFS_CTRL, 32'h3);
    wr(OFS_FLAGS, 32'h0);
    wr(OFS_EVGEN, 32'h1);
    rd(OFS_FLAGS, v);
    chk(32'(v[BIT_UPFLAG]), 32'h0);
    wr(OFS_CTRL, 32'h1);
  endtask

  task automatic t_presc;
    wr(OFS_RELOAD, 32'hFFFF);
    wr(OFS_EVGEN, 32'h1);
    meas;
    rng(dv, 32'd198, 32'd202);
    wr(OFS_PRESC, 32'h9);
    meas;
    rng(dv, 32'd198, 32'd202);
    wr(OFS_EVGEN, 32'h1);
    meas;
    rng(dv, 32'd19, 32'd21);
    halted <= 1'b1;
    hold <= 1'b1;
    @(posedge aclk);
    meas;
    chk(dv, 32'h0);
    hold <= 1'b0;
    @(posedge aclk);
    meas;
    rng(dv, 32'd19, 32'd21);
    halted <= 1'b0;
    wr(OFS_PRESC, 32'h0);
    wr(OFS_RELOAD, 32'h9);
    wr(OFS_EVGEN, 32'h1);
  endtask

  task automatic t_cmp;
    wr(OFS_INTEN, 32'h2);
    wr(OFS_CHOUT, 32'h1);
    setm(CMP_HIGH);
    chk(32'(chout), 32'h1);
    chk(32'(choe), 32'h1);
    setm(CMP_LOW);
    chk(32'(chout), 32'h0);
    wr(OFS_CHOUT, 32'h3);
    setm(CMP_LOW);
    chk(32'(chout), 32'h1);
    wr(OFS_CHOUT, 32'h1);
    wr(OFS_CHVAL, 32'h4);
    wr(OFS_FLAGS, 32'h0);
    setm(CMP_SET);
    repeat (20) @(posedge aclk);
    chk(32'(chout), 32'h1);
    rd(OFS_FLAGS, v);
    chk(32'(v[BIT_CHFLAG]), 32'h1);
    chk(32'(cirq), 32'h1);
    setm(CMP_CLEAR);
    repeat (20) @(posedge aclk);
    chk(32'(chout), 32'h0);
    // one counter period is ten cycles, so exactly one match falls between samples
    setm(CMP_TOGGLE);
    v = 32'(chout);
    repeat (10) @(posedge aclk);
    chk(32'(chout), v ^ 32'h1);
    setm(CMP_FROZEN);
    v = 32'(chout);
    repeat (25) @(posedge aclk);
    chk(32'(chout), v);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_FLAGS, 32'h0);
    wr(OFS_EVGEN, 32'h2);
    rd(OFS_FLAGS, v);
    chk(v, 32'h2);
    wr(OFS_CTRL, 32'h1);
  endtask

  task automatic t_pwm;
    wr(OFS_CHVAL, 32'hC);
    setm(CMP_PWM0);
    ones;
    chk(n, 32'd10);
    wr(OFS_CHVAL, 32'h0);
    ones;
    chk(n, 32'd0);
    wr(OFS_CHVAL, 32'h5);
    ones;
    chk(n, 32'd5);
    setm(CMP_PWM1);
    wr(OFS_CHVAL, 32'h3);
    ones;
    chk(n, 32'd7);
    wr(OFS_CTRL, 32'h3);
    wr(OFS_CHCTL, (32'(CMP_PWM0) << POS_CMPCTL) | (32'h1 << BIT_SHADOW));
    wr(OFS_CHVAL, 32'h8);
    ones;
    chk(n, 32'd3);
    wr(OFS_CTRL, 32'h1);
    ones;
    ones;
    chk(n, 32'd8);
  endtask

  task automatic t_cap;
    wr(OFS_CTRL, 32'h0);
    wr(OFS_COUNT, 32'h123);
    wr(OFS_CHCTL, 32'h1);
    chk(32'(choe), 32'h0);
    wr(OFS_FLAGS, 32'h0);
    chin <= 1'b1;
    repeat (10) @(posedge aclk);
    rd(OFS_FLAGS, v);
    chk(v, 32'h2);
    chk(32'(cirq), 32'h1);
    rd(OFS_CHVAL, v);
    chk(v, 32'h123);
    wr(OFS_CHVAL, 32'h55);
    rd(OFS_CHVAL, v);
    chk(v, 32'h123);
    wr(OFS_COUNT, 32'h200);
    chin <= 1'b0;
    repeat (10) @(posedge aclk);
    chin <= 1'b1;
    repeat (10) @(posedge aclk);
    rd(OFS_FLAGS, v);
    chk(v, 32'h202);
    wr(OFS_CHOUT, 32'h3);
    wr(OFS_COUNT, 32'h300);
    chin <= 1'b0;
    repeat (10) @(posedge aclk);
    rd(OFS_CHVAL, v);
    chk(v, 32'h300);
    // both edges, two edges per capture, a one-cycle glitch must not pass the filter
    wr(OFS_CHOUT, 32'hB);
    wr(OFS_CHCTL, 32'h15);
    wr(OFS_COUNT, 32'h400);
    wr(OFS_FLAGS, 32'h0);
    chin <= 1'b1;
    @(posedge aclk);
    chin <= 1'b0;
    repeat (10) @(posedge aclk);
    rd(OFS_FLAGS, v);
    chk(v, 32'h0);
    chin <= 1'b1;
    repeat (10) @(posedge aclk);
    rd(OFS_FLAGS, v);
    chk(v, 32'h0);
    chin <= 1'b0;
    repeat (10) @(posedge aclk);
    rd(OFS_CHVAL, v);
    chk(v, 32'h400);
  endtask

  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // the scenarios need a few thousand cycles; this leaves wide margin
  initial begin
    repeat (30000) @(posedge aclk);
    n_mismatch++;
    give_verdict;
  end

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_count;
    t_presc;
    t_cmp;
    t_pwm;
    t_cap;
    give_verdict;
  end
endmodule
